// *** acr_top.sv ***
//
// Behaviour
// - every 32-bit register is held as four byte locations, each addressed alone.
// - a register at base A keeps bits 7:0 at A, 15:8 at A+1, 23:16 at A+2, 31:24 at A+3.
// - nine registers sit at bases 00h, 04h, 08h, 0Ch, 10h, 14h, 20h, 24h and 28h.
// - the identification register holds a four-bit node address in bits 19:16.
// - reserved bits are read-only and always read back as zero.
// - bits 5:0 of the reset/power register take writes only while the key byte holds 69h; a reset-pin clear needs no key.
// - bit 5 set disables the supply alarm, clear enables it, reset value zero.
// - bit 4 set disables the input alarm, clear enables it, reset value zero.
// - with bit 2 clear the reset pin does a full init, set it does an app reset.
// - once bit 2 is set it stays set until the next power-on reset.
// - with bit 1 set the converter sleeps after a conversion while start is high.
// - bit 0 set powers the converter down, clear keeps it active, reset value zero.
// - power-on-only fields survive an app reset, all other fields are cleared.
// - after a power-on reset or a full init the link works in clock polarity 0 and phase 0.
`timescale 1ns/10ps
`include "acr_regs.svh"
module acr_top
  import acr_pkg::*;
(
  // core clock and power-on reset
  input wire logic core_clk,
  input wire logic rstn,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  // reset pin and converter status
  input wire logic rst_pin_n,
  input wire logic conversion_start_input,
  input wire logic conversion_done,
  // controls to the converter
  output logic supply_alarm_en,
  output logic input_alarm_en,
  output logic light_sleep,
  output logic power_down,
  output logic [1:0] serial_protocol_select,
  output logic [3:0] node_address
);
  localparam int NBYTE = `ACR_NREG * `ACR_NLANE;

  function automatic acr_byte_t wmask_f(input int r, input int b);
    acr_byte_t m;
    m = `ACR_M_NONE;
    case (r)
      0: m = (b == 2) ? `ACR_M_ID2 : `ACR_M_NONE;
      1: m = (b == 0) ? `ACR_M_PWR0 : (b == 1) ? `ACR_M_FULL : `ACR_M_NONE;
      2: m = (b == 0) ? `ACR_M_SDI0 : `ACR_M_NONE;
      3: m = (b == 0) ? `ACR_M_SDO0 : (b == 1) ? `ACR_M_SDO1 : `ACR_M_NONE;
      default: m = `ACR_M_FULL;
    endcase
    return m;
  endfunction

  function automatic acr_byte_t por_f(input int r, input int b);
    acr_byte_t m;
    m = `ACR_M_NONE;
    if (b == 0) begin
      case (r)
        1: m = `ACR_P_PWR0;
        2: m = `ACR_P_SDI0;
        3: m = `ACR_P_SDO0;
        default: m = `ACR_M_NONE;
      endcase
    end
    return m;
  endfunction

  function automatic logic [3:0] idx_f(input logic [7:0] base);
    logic [3:0] i;
    i = `ACR_I_NONE;
    case (base)
      `ACR_A_ID: i = 4'd0;
      `ACR_A_RSTPWR: i = 4'd1;
      `ACR_A_SDI: i = 4'd2;
      `ACR_A_SDO: i = 4'd3;
      `ACR_A_DOUT: i = 4'd4;
      `ACR_A_RANGE: i = 4'd5;
      `ACR_A_ALARM: i = 4'd6;
      `ACR_A_ALM_HI: i = 4'd7;
      `ACR_A_ALM_LO: i = 4'd8;
      default: i = `ACR_I_NONE;
    endcase
    return i;
  endfunction

  // ---------------- serial clock domain ----------------
  logic [5:0] bit_cnt_r;
  logic [31:0] shift_r;
  logic [31:0] hold_r;
  logic req_tgl_r;
  logic ack_s1_r;
  logic ack_s2_r;
  acr_byte_t out_sh_r;
  logic sdo_r;
  logic ack_tgl_r;
  acr_byte_t rd_data_r;
  wire frame_full = (bit_cnt_r == `ACR_FRAME_LAST);
  wire rd_ready = (ack_s2_r == req_tgl_r);
  wire acr_byte_t rd_load = rd_ready ? rd_data_r : `ACR_BYTE_RST;

  // frame select ends the count, so a stopped clock cannot leave it hanging;
  // only mode 0 sampling is built, other protocols are exported for the pads
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_r <= 6'd0;
    end else if (bit_cnt_r != `ACR_CNT_MAX) begin
      bit_cnt_r <= bit_cnt_r + 6'd1;
    end
  end

  // a word is handed over only on the 32nd edge, shorter frames are dropped
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      shift_r <= 32'h0000_0000;
      hold_r <= 32'h0000_0000;
      req_tgl_r <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      shift_r <= {shift_r[30:0], sdi};
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      if (frame_full && !cs_n) begin
        hold_r <= {shift_r[30:0], sdi};
        req_tgl_r <= ~req_tgl_r;
      end
    end
  end

  // read byte of the previous frame goes out after two edges of sync
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_sh_r <= `ACR_BYTE_RST;
      sdo_r <= 1'b0;
    end else if (bit_cnt_r == `ACR_RD_LOAD) begin
      sdo_r <= rd_load[7];
      out_sh_r <= {rd_load[6:0], 1'b0};
    end else begin
      sdo_r <= out_sh_r[7];
      out_sh_r <= {out_sh_r[6:0], 1'b0};
    end
  end
  assign sdo = sdo_r;

  // ---------------- core clock domain ----------------
  logic req_s1_r;
  logic req_s2_r;
  logic req_s3_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;
  logic cst_s1_r;
  logic cst_s2_r;
  wire frame_pulse = req_s2_r ^ req_s3_r;
  wire [7:0] f_op = hold_r[`ACR_F_OP];
  wire [7:0] f_addr = hold_r[`ACR_F_ADDR];
  wire acr_byte_t f_data = hold_r[`ACR_F_DATA];
  wire [3:0] f_idx = idx_f({f_addr[7:2], 2'b00});
  wire [1:0] f_lane = f_addr[1:0];
  wire f_hit = (f_idx != `ACR_I_NONE);
  wire f_wr = frame_pulse && (f_op == `ACR_OP_WRITE) && f_hit;
  wire f_rd = frame_pulse && (f_op == `ACR_OP_READ);
  wire [5:0] f_byte = {f_idx, 2'b00} + {4'd0, f_lane};

  acr_byte_t bq [NBYTE];
  wire acr_byte_t pwr0 = bq[4];
  wire key_ok = (bq[5] == `ACR_KEY);
  wire class_app = pwr0[`ACR_B_CLASS];
  wire pin_fall = pin_s3_r && !pin_s2_r;
  wire por_clr = pin_fall && !class_app;
  wire app_clr = pin_fall && class_app;
  // class bit is set-only by writes, so only a power-on reset can clear it
  wire acr_byte_t pwr_wdata = f_data | (pwr0 & `ACR_S_PWR0);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_s3_r <= 1'b1;
      cst_s1_r <= 1'b0;
      cst_s2_r <= 1'b0;
    end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      pin_s1_r <= rst_pin_n;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      cst_s1_r <= conversion_start_input;
      cst_s2_r <= cst_s1_r;
    end
  end

  // one byte location per address, masks drop reserved bits
  for (genvar r = 0; r < `ACR_NREG; r++) begin : g_reg
    for (genvar b = 0; b < `ACR_NLANE; b++) begin : g_lane
      localparam int N = r * `ACR_NLANE + b;
      wire we_b = f_wr && (f_byte == 6'(N)) && ((N != 4) || key_ok);
      acr_byte_reg #(
        .WMASK(wmask_f(r, b)),
        .POR_ONLY(por_f(r, b))
      ) u_byte (
        .core_clk(core_clk),
        .rstn(rstn),
        .por_clr(por_clr),
        .app_clr(app_clr),
        .we(we_b),
        .wdata((N == 4) ? pwr_wdata : f_data),
        .q(bq[N])
      );
    end
  end

  // read data settles before the ack toggle is seen on the link side
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_r <= `ACR_BYTE_RST;
      ack_tgl_r <= 1'b0;
    end else begin
      if (f_rd) begin
        rd_data_r <= f_hit ? bq[f_byte] : `ACR_BYTE_RST;
      end
      ack_tgl_r <= req_s3_r;
    end
  end

  // power state
  acr_pwr_state_t state_r;
  acr_pwr_state_t state_nxt;
  logic sleep_r;
  logic pd_r;
  logic sup_en_r;
  logic in_en_r;
  wire sleep_en = pwr0[`ACR_B_SLEEP];
  wire pd_req = pwr0[`ACR_B_PD];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ACR_ACTIVE: begin
        if (pd_req) begin
          state_nxt = ACR_POWER_DOWN;
        end else if (sleep_en && conversion_done && cst_s2_r) begin
          state_nxt = ACR_LIGHT_SLEEP;
        end
      end
      ACR_LIGHT_SLEEP: begin
        if (pd_req) begin
          state_nxt = ACR_POWER_DOWN;
        end else if (!sleep_en || !cst_s2_r) begin
          state_nxt = ACR_ACTIVE;
        end
      end
      ACR_POWER_DOWN: begin
        if (!pd_req) begin
          state_nxt = ACR_ACTIVE;
        end
      end
      default: state_nxt = ACR_ACTIVE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ACR_ACTIVE;
      sleep_r <= 1'b0;
      pd_r <= 1'b0;
      sup_en_r <= 1'b1;
      in_en_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      sleep_r <= (state_nxt == ACR_LIGHT_SLEEP);
      pd_r <= (state_nxt == ACR_POWER_DOWN);
      sup_en_r <= ~pwr0[`ACR_B_SUP_AL];
      in_en_r <= ~pwr0[`ACR_B_IN_AL];
    end
  end

  assign light_sleep = sleep_r;
  assign power_down = pd_r;
  assign supply_alarm_en = sup_en_r;
  assign input_alarm_en = in_en_r;
  assign serial_protocol_select = bq[8][`ACR_F_PROTO];
  assign node_address = bq[2][`ACR_F_NODE];

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  key_gate_a: assert property (
    f_wr && f_byte == 6'd4 && !key_ok && !pin_fall |=> $stable(bq[4]))
    else $error("control bits changed without key");
  key_open_a: assert property (
    f_wr && f_byte == 6'd4 && key_ok && !pin_fall
    |=> bq[4] == (($past(f_data) | ($past(bq[4]) & `ACR_S_PWR0))
    & `ACR_M_PWR0))
    else $error("keyed control write not stored");
  reserved_zero_a: assert property (
    (bq[4] & ~`ACR_M_PWR0) == 8'h00 && bq[6] == 8'h00 && bq[7] == 8'h00
    && bq[0] == 8'h00 && (bq[2] & ~`ACR_M_ID2) == 8'h00)
    else $error("reserved bits not zero");
  node_field_a: assert property (
    f_wr && f_byte == 6'd2 && !pin_fall
    |=> node_address == $past(f_data[3:0]))
    else $error("node address not written");
  lane_map_a: assert property (
    f_wr && f_addr == (`ACR_A_RANGE + 8'h02) && !pin_fall
    |=> bq[22] == $past(f_data) && $stable(bq[21]))
    else $error("byte lane mapping wrong");
  app_keep_a: assert property (
    app_clr |=> $stable(bq[4][2:1]) && !bq[4][`ACR_B_PD] && bq[5] == 8'h00)
    else $error("application reset mishandled");
  class_sticky_a: assert property (
    class_app && !por_clr |=> class_app)
    else $error("reset class bit lost");
  sleep_entry_a: assert property (
    state_r == ACR_ACTIVE && sleep_en && conversion_done && cst_s2_r
    && !pd_req |=> light_sleep ##0 !power_down)
    else $error("light sleep not entered");
  sleep_never_a: assert property (
    !sleep_en |=> !light_sleep)
    else $error("light sleep while disabled");
  pd_follow_a: assert property (
    pd_req |=> power_down && !light_sleep)
    else $error("power down not followed");
  unmapped_read_a: assert property (
    f_rd && !f_hit |=> rd_data_r == `ACR_BYTE_RST)
    else $error("unmapped read not zero");
  pd_exit_a: assert property (
    state_r == ACR_POWER_DOWN && !pd_req |=> !power_down)
    else $error("power down not left");
  alarm_dis_a: assert property (
    ##1 supply_alarm_en == !$past(pwr0[5]) && input_alarm_en == !$past(pwr0[4]))
    else $error("alarm enable mismatch");
endmodule

// *** acr_regs.svh ***
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// serial frame: opcode, byte address, data byte, pad byte
`define ACR_F_OP 31:24
`define ACR_F_ADDR 23:16
`define ACR_F_DATA 15:8
`define ACR_FRAME_LAST 6'd31
`define ACR_CNT_MAX 6'd32
`define ACR_RD_LOAD 6'd2
`define ACR_OP_WRITE 8'h01
`define ACR_OP_READ 8'h02

// register base byte addresses
`define ACR_A_ID 8'h00
`define ACR_A_RSTPWR 8'h04
`define ACR_A_SDI 8'h08
`define ACR_A_SDO 8'h0C
`define ACR_A_DOUT 8'h10
`define ACR_A_RANGE 8'h14
`define ACR_A_ALARM 8'h20
`define ACR_A_ALM_HI 8'h24
`define ACR_A_ALM_LO 8'h28

// register indices
`define ACR_NREG 9
`define ACR_NLANE 4
`define ACR_I_ID 4'd0
`define ACR_I_RSTPWR 4'd1
`define ACR_I_SDI 4'd2
`define ACR_I_SDO 4'd3
`define ACR_I_NONE 4'd15

// reset and power control fields
`define ACR_KEY 8'h69
`define ACR_B_SUP_AL 5
`define ACR_B_IN_AL 4
`define ACR_B_CLASS 2
`define ACR_B_SLEEP 1
`define ACR_B_PD 0
`define ACR_F_NODE 3:0
`define ACR_F_PROTO 1:0

// writable masks and power-on-only masks per byte
`define ACR_M_NONE 8'h00
`define ACR_M_FULL 8'hFF
`define ACR_M_ID2 8'h0F
`define ACR_M_PWR0 8'h37
`define ACR_P_PWR0 8'h06
`define ACR_S_PWR0 8'h04
`define ACR_M_SDI0 8'h03
`define ACR_P_SDI0 8'h03
`define ACR_M_SDO0 8'h43
`define ACR_P_SDO0 8'h43
`define ACR_M_SDO1 8'h13
`define ACR_BYTE_RST 8'h00

`endif

// *** acr_pkg.sv ***
package acr_pkg;
  typedef enum logic [1:0] {
    ACR_ACTIVE,
    ACR_LIGHT_SLEEP,
    ACR_POWER_DOWN
  } acr_pwr_state_t;
  typedef logic [7:0] acr_byte_t;
endpackage

// *** acr_byte_reg.sv ***
`timescale 1ns/10ps
`include "acr_regs.svh"
module acr_byte_reg
  import acr_pkg::*;
#(
  parameter acr_byte_t WMASK = `ACR_M_FULL,
  parameter acr_byte_t POR_ONLY = `ACR_M_NONE
) (
  // clock and resets
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic por_clr,
  input wire logic app_clr,
  // write port
  input wire logic we,
  input wire acr_byte_t wdata,
  // stored value
  output acr_byte_t q
);
  acr_byte_t q_r;
  acr_byte_t q_nxt;

  // bits outside the mask are never touched, so reserved bits stay zero
  assign q_nxt = por_clr ? `ACR_BYTE_RST :
                 app_clr ? (q_r & POR_ONLY) :
                 we ? ((q_r & ~WMASK) | (wdata & WMASK)) : q_r;
  assign q = q_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= `ACR_BYTE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule

// *** acr_host.sv ***
`timescale 1ns/10ps
module acr_host (
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  // byte taken from sdo in the last frame
  output logic [7:0] rd_byte
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b1;
    rd_byte = 8'h00;
  end

  // always 32 edges, so every write counts; clock idles low between
  task automatic frame(input logic [31:0] w);
    #3 cs_n = 1'b0;
    for (int k = 1; k <= 32; k++) begin
      sdi = w[32-k];
      #40 sclk = 1'b1;
      if (k >= 3 && k <= 10) rd_byte = {rd_byte[6:0], sdo};
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    // released line must not keep a believable value
    sdi = ~sdi;
    #80;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    frame({8'h01, a, d, 8'h00});
  endtask

  // power control is only written behind the key
  task automatic uwr(input logic [7:0] d);
    wr(8'h05, 8'h69);
    wr(8'h04, d);
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import acr_pkg::*;
  logic core_clk, rstn, rst_pin_n;
  logic conversion_start_input, conversion_done;
  logic sclk, cs_n, sdi, sdo;
  logic supply_alarm_en, input_alarm_en, light_sleep, power_down;
  logic [1:0] proto;
  logic [3:0] node;
  logic [7:0] rd_byte, ctrl_v;
  logic [31:0] seed = 32'heb13_3753;
  int n_mismatch = 0;
  int comparisons = 0;
  acr_byte_t exp_q[$];
  event rd_done;

  assign ctrl_v = {4'h0, supply_alarm_en, input_alarm_en, light_sleep,
                   power_down};

  acr_top u_acr_top (
    .core_clk(core_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo), .rst_pin_n(rst_pin_n),
    .conversion_start_input(conversion_start_input),
    .conversion_done(conversion_done),
    .supply_alarm_en(supply_alarm_en), .input_alarm_en(input_alarm_en),
    .light_sleep(light_sleep), .power_down(power_down),
    .serial_protocol_select(proto), .node_address(node)
  );

  acr_host u_acr_host (
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .rd_byte(rd_byte)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // read answer comes back in the following frame
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_acr_host.frame({8'h02, a, 16'h0000});
    u_acr_host.frame(32'h0000_0000);
    ->rd_done;
  endtask

  task automatic pin();
    cyc(1);
    rst_pin_n = 1'b0;
    cyc(4);
    rst_pin_n = 1'b1;
    cyc(8);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial forever begin
    @(rd_done);
    chk("read byte", rd_byte, exp_q.pop_front());
  end

  initial begin
    #600000;
    n_mismatch++;
    $display("ERROR watchdog expected done seen hang");
    conclude();
  end

  initial begin
    logic [7:0] bases [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                              8'h20, 8'h24, 8'h28};
    logic [7:0] v [9][4];
    rstn = 1'b0;
    rst_pin_n = 1'b1;
    conversion_start_input = 1'b0;
    conversion_done = 1'b0;
    cyc(3);
    rstn = 1'b1;
    cyc(2);
    chk("ctrl", ctrl_v, 8'h0c);
    chk("node", {4'h0, node}, 8'h00);
    for (int a = 0; a < 8; a++) rd(8'(a), 8'h00);
    $display("test reset values done");

    for (int i = 4; i < 9; i++) begin
      for (int l = 0; l < 4; l++) begin
        seed = xs(seed);
        v[i][l] = seed[7:0];
        u_acr_host.wr(bases[i] + 8'(l), v[i][l]);
      end
    end
    for (int i = 4; i < 9; i++) rd(bases[i] + 8'(i % 4), v[i][i % 4]);
    u_acr_host.wr(8'h18, 8'hff);
    rd(8'h18, 8'h00);
    rd(8'h2c, 8'h00);
    $display("test register map done");

    u_acr_host.wr(8'h02, 8'hff);
    rd(8'h02, 8'h0f);
    chk("node", {4'h0, node}, 8'h0f);
    u_acr_host.wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    $display("test node address done");

    u_acr_host.wr(8'h04, 8'hff);
    rd(8'h04, 8'h00);
    chk("ctrl", ctrl_v, 8'h0c);
    u_acr_host.uwr(8'hff);
    rd(8'h04, 8'h37);
    rd(8'h05, 8'h69);
    chk("ctrl", ctrl_v, 8'h01);
    $display("test key done");

    u_acr_host.uwr(8'h02);
    rd(8'h04, 8'h06);
    chk("ctrl", ctrl_v, 8'h0c);
    for (int e = 1; e >= 0; e--) begin
      conversion_start_input = 1'b1;
      cyc(4);
      conversion_done = 1'b1;
      cyc(1);
      conversion_done = 1'b0;
      cyc(3);
      chk("sleep", ctrl_v, e ? 8'h0e : 8'h0c);
      conversion_start_input = 1'b0;
      cyc(5);
      chk("wake", ctrl_v, 8'h0c);
      u_acr_host.uwr(8'h00);
    end
    cyc(1);
    for (int k = 0; k < 16; k++) begin
      seed = xs(seed);
      conversion_start_input = seed[0];
      conversion_done = seed[1];
      cyc(1);
      conversion_done = 1'b0;
      cyc(1);
      chk("no sleep", ctrl_v, 8'h0c);
    end
    conversion_start_input = 1'b0;
    $display("test light sleep done");

    u_acr_host.uwr(8'h37);
    seed = xs(seed);
    u_acr_host.wr(8'h02, seed[7:0]);
    pin();
    chk("ctrl", ctrl_v, 8'h0c);
    chk("node", {4'h0, node}, 8'h00);
    rd(8'h04, 8'h06);
    rd(8'h05, 8'h00);
    rd(8'h10, 8'h00);
    pin();
    rd(8'h04, 8'h06);
    cyc(1);
    rstn = 1'b0;
    cyc(3);
    rstn = 1'b1;
    cyc(2);
    rd(8'h04, 8'h00);
    u_acr_host.uwr(8'h01);
    pin();
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    chk("ctrl", ctrl_v, 8'h0c);
    $display("test reset classes done");

    u_acr_host.wr(8'h08, 8'hff);
    chk("proto", {6'h00, proto}, 8'h03);
    pin();
    chk("proto", {6'h00, proto}, 8'h00);
    $display("test protocol select done");
    cyc(4);
    conclude();
  end
endmodule
